// [hw/cpc_foldback.sv]
// Purpose: thermal foldback of the charge current target
// Assumes: excess is whole degrees above the regulation point
// Notes: purely combinational, caller registers the result
module cpc_foldback import cpc_pkg::*; (
	input wire logic [6:0] base_pct,
	input wire logic [4:0] excess_c,
	output logic [6:0] out_pct
);
	// ==========================================================
	// linear slope, clamped at zero
	logic [11:0] cut;
	logic at_zero;
	assign cut = 12'(excess_c) * 12'(FOLD_STEP_PCT);
	assign at_zero = excess_c >= FOLD_ZERO_C;
	assign out_pct = (at_zero || cut >= 12'(base_pct)) ? 7'h00 : base_pct - cut[6:0];
endmodule

// [hw/cpc_pkg.sv]
// Purpose: shared constants and types for the charger protection control
// Assumes: 40 MHz pclk, analog comparators deliver digital flags
// Notes: long counts are scaled through a millisecond tick
package cpc_pkg;
	// ==========================================================
	// timing
	localparam int CLK_MHZ = 40;
	localparam int MS_CYC = CLK_MHZ * 1000;
	localparam int BOOST_OFF_MS = 300;
	localparam int BOOST_ON_MS = 60;
	localparam int OCP_DEB_NS = 10000;
	localparam int OCP_DEB_CYC = (OCP_DEB_NS * CLK_MHZ + 999) / 1000;
	localparam int OCP_RETRY_MS = 100;
	localparam int TOPOFF_MS = 30;
	localparam int FC_LIMIT_MS = 3600000;
	localparam int TO_LIMIT_MS = 1800000;
	// ==========================================================
	// current and voltage targets
	localparam logic [6:0] CUR_FULL_PCT = 7'h64;
	localparam logic [6:0] CUR_COOL_PCT = 7'h32;
	localparam logic [6:0] FOLD_STEP_PCT = 7'h05;
	localparam logic [4:0] FOLD_ZERO_C = 5'h14;
	localparam int VTERM_DROP_MV = 150;
	// ==========================================================
	// register map
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_TARGET = 8'h08;
	localparam logic [31:0] CTRL_RST = 32'h0000_0001;
	localparam int CTRL_JEITA_BIT = 0;
	// ==========================================================
	// charge states, gray along idle-cc-cv-topoff-done
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_FASTCC = 3'h1,
		ST_CV = 3'h3,
		ST_TOPOFF = 3'h2,
		ST_DONE = 3'h6,
		ST_BUCK = 3'h7,
		ST_TFAULT = 3'h5,
		ST_TSHDN = 3'h4
	} cpc_state_t;
	typedef struct packed {
		logic input_valid;
		logic thm_low;
		logic tj_shdn;
		logic battery_node_restart;
		logic battery_node_at_reg;
		logic term_low;
		logic cold;
		logic cool;
		logic warm;
		logic hot;
		logic boost_en;
		logic charger_input_low;
		logic boost_ovl;
		logic cc1_sink;
		logic cc2_sink;
		logic battery_node_oc;
		logic sys_low;
	} cpc_flags_t;
endpackage

// [hw/cpc_sync.sv]
// Purpose: two-stage synchronizer for the comparator flags
// Assumes: flags are asynchronous to pclk
// Notes: first stage feeds only the second stage
module cpc_sync import cpc_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire cpc_flags_t d,
	output cpc_flags_t q
);
	// ==========================================================
	// per-bit chain
	logic [$bits(cpc_flags_t)-1:0] meta_q;
	logic [$bits(cpc_flags_t)-1:0] sync_q;
	genvar i;
	generate
		for (i = 0; i < $bits(cpc_flags_t); i++) begin : g_bit
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					meta_q[i] <= 1'b0;
					sync_q[i] <= 1'b0;
				end else begin
					meta_q[i] <= d[i];
					sync_q[i] <= meta_q[i];
				end
			end
		end
	endgenerate
	assign q = cpc_flags_t'(sync_q);
endmodule

// [hw/cpc_top.sv]
// Purpose: charge state tail, reverse boost and battery protection control
// Assumes: flags come from comparators, tj_excess from same-clock logic
// Notes: prequal and trickle entry are outside this block
// What this block does
// - top-off ends in done after duration
// - done returns to fast charge on restart
// - done state commands zero charge current
// - done to fast charge skips soft start
// - safety timer limits dwell, enters fault
// - timer fault releases status pin
// - timer fault held until input re-applied or thermal shutdown
// - overtemperature enters thermal shutdown, charger off
// - boost only with enable and low input
// - boost overload opens switch, retries later
// - persistent overload cycles 60 on 300 off
// - source pins low power until sink seen
// - debounced battery overcurrent kills discharge, buck
// - overcurrent retries after system rail low
// - foldback five percent per degree
// - zero current twenty degrees above point
// - grounded thermistor pin disables charging
// - cool zone halves fast-charge current
// - warm zone drops termination 150 mV
// - cold or hot suspends charging
// - hot/cold variant skips cool, warm adjust
// - idle forces zero current, clears timer
// - thermistor level moves to buck, resumes
module cpc_top import cpc_pkg::*; #(
	parameter int TICK_CYC = MS_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire cpc_flags_t flags_pin,
	input wire logic [4:0] tj_excess,
	output logic charger_en,
	output logic [6:0] ichg_pct,
	output logic vterm_drop,
	output logic softstart_en,
	output logic stat_o,
	output logic stat_oe_n,
	output logic boost_mode,
	output logic boost_sw_on,
	output logic cc_low_power,
	output logic cc1_src_en,
	output logic cc2_src_en,
	output logic battery_node_dis_en,
	output logic buck_en
);
	// ==========================================================
	// flags and millisecond tick
	cpc_flags_t f;
	cpc_sync u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d(flags_pin),
		.q(f)
	);
	logic [15:0] tick_cnt_q;
	logic ms_tick;
	assign ms_tick = tick_cnt_q == 16'(TICK_CYC - 1);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) tick_cnt_q <= 16'h0000;
		else tick_cnt_q <= ms_tick ? 16'h0000 : tick_cnt_q + 16'h0001;
	end
	// ==========================================================
	// registers over apb
	logic [31:0] ctrl_q;
	logic jeita_full;
	logic hit_ctrl, hit_stat, hit_tgt, acc_setup;
	assign jeita_full = ctrl_q[CTRL_JEITA_BIT];
	assign acc_setup = psel && !penable;
	assign hit_ctrl = paddr == REG_CTRL;
	assign hit_stat = paddr == REG_STATUS;
	assign hit_tgt = paddr == REG_TARGET;
	// ==========================================================
	// charge state machine
	cpc_state_t state_q, state_d;
	logic [23:0] st_ms_q;
	logic charging, suspend, fc_expired, to_expired, topoff_done, tmr_clr;
	assign charging = state_q inside {ST_FASTCC, ST_CV, ST_TOPOFF};
	assign suspend = f.cold || f.hot;
	assign fc_expired = st_ms_q >= 24'(FC_LIMIT_MS);
	assign to_expired = st_ms_q >= 24'(TO_LIMIT_MS);
	assign topoff_done = st_ms_q >= 24'(TOPOFF_MS);
	// cc and cv share one fast-charge budget
	assign tmr_clr = state_d != state_q && !(state_q == ST_FASTCC && state_d == ST_CV);
	always_comb begin
		state_d = state_q;
		if (f.tj_shdn) begin
			state_d = ST_TSHDN;
		end else if (!f.input_valid) begin
			state_d = ST_IDLE;
		end else if (state_q == ST_TFAULT) begin
			state_d = ST_TFAULT;
		end else if (f.thm_low) begin
			state_d = ST_BUCK;
		end else begin
			unique case (state_q)
				ST_IDLE, ST_BUCK, ST_TSHDN: begin
					state_d = ST_FASTCC;
				end
				ST_FASTCC: begin
					if (fc_expired) state_d = ST_TFAULT;
					else if (f.battery_node_at_reg) state_d = ST_CV;
				end
				ST_CV: begin
					if (fc_expired) state_d = ST_TFAULT;
					else if (f.term_low) state_d = ST_TOPOFF;
				end
				ST_TOPOFF: begin
					if (to_expired) state_d = ST_TFAULT;
					else if (f.battery_node_restart) state_d = ST_FASTCC;
					else if (topoff_done) state_d = ST_DONE;
				end
				ST_DONE: begin
					if (f.battery_node_restart) state_d = ST_FASTCC;
				end
				ST_TFAULT: begin
					state_d = ST_TFAULT;
				end
			endcase
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_IDLE;
			st_ms_q <= 24'h000000;
		end else begin
			state_q <= state_d;
			if (tmr_clr || state_q == ST_IDLE) st_ms_q <= 24'h000000;
			else if (charging && !suspend && ms_tick) st_ms_q <= st_ms_q + 24'h000001;
		end
	end
	// ==========================================================
	// current and voltage targets
	logic cool_cut, warm_drop, ss_d;
	logic [6:0] base_pct, fold_pct, ichg_d;
	// hot/cold-only variant keeps full targets in cool and warm
	assign cool_cut = jeita_full && f.cool && !f.cold;
	assign warm_drop = jeita_full && f.warm && !f.hot;
	assign base_pct = cool_cut ? CUR_COOL_PCT : CUR_FULL_PCT;
	cpc_foldback u_fold (
		.base_pct(base_pct),
		.excess_c(tj_excess),
		.out_pct(fold_pct)
	);
	// done, idle, buck and faults all fall to zero here
	assign ichg_d = (charging && !suspend) ? fold_pct : 7'h00;
	assign ss_d = (state_d == ST_FASTCC && state_q != ST_FASTCC) ?
		state_q != ST_DONE : softstart_en;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			charger_en <= 1'b0;
			ichg_pct <= 7'h00;
			vterm_drop <= 1'b0;
			softstart_en <= 1'b0;
			stat_o <= 1'b0;
			stat_oe_n <= 1'b1;
		end else begin
			charger_en <= charging && !suspend && !f.tj_shdn;
			ichg_pct <= ichg_d;
			vterm_drop <= warm_drop;
			softstart_en <= ss_d;
			stat_o <= 1'b0;
			stat_oe_n <= !charging;
		end
	end
	// ==========================================================
	// reverse boost switch and source pins
	logic boost_act, blank_q;
	logic [8:0] bst_ms_q;
	logic [1:0] cc_sel_q;
	assign boost_act = f.boost_en && f.charger_input_low;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			boost_mode <= 1'b0;
			boost_sw_on <= 1'b0;
			blank_q <= 1'b0;
			bst_ms_q <= 9'h000;
		end else begin
			boost_mode <= boost_act;
			if (!boost_act) begin
				boost_sw_on <= boost_act;
				blank_q <= 1'b0;
				bst_ms_q <= 9'h000;
			end else if (!boost_mode) begin
				boost_sw_on <= 1'b1;
			end else if (boost_sw_on && !blank_q && f.boost_ovl) begin
				boost_sw_on <= 1'b0;
				bst_ms_q <= 9'h000;
			end else if (!boost_sw_on) begin
				if (bst_ms_q == 9'(BOOST_OFF_MS)) begin
					boost_sw_on <= 1'b1;
					blank_q <= 1'b1;
					bst_ms_q <= 9'h000;
				end else if (ms_tick) begin
					bst_ms_q <= bst_ms_q + 9'h001;
				end
			end else if (blank_q) begin
				// retry stays closed for the on window before judging load
				if (bst_ms_q == 9'(BOOST_ON_MS)) blank_q <= 1'b0;
				else if (ms_tick) bst_ms_q <= bst_ms_q + 9'h001;
			end
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cc_sel_q <= 2'h0;
			cc_low_power <= 1'b0;
			cc1_src_en <= 1'b0;
			cc2_src_en <= 1'b0;
		end else begin
			if (!boost_act || !(f.cc1_sink || f.cc2_sink)) cc_sel_q <= 2'h0;
			else if (cc_sel_q == 2'h0) cc_sel_q <= f.cc1_sink ? 2'h1 : 2'h2;
			cc_low_power <= boost_act && cc_sel_q == 2'h0;
			cc1_src_en <= cc_sel_q[0];
			cc2_src_en <= cc_sel_q[1];
		end
	end
	// ==========================================================
	// battery overcurrent with auto retry
	logic ocp_fault_q;
	logic [8:0] ocp_cnt_q;
	logic [7:0] ocp_ms_q;
	logic ocp_trip, ocp_retry;
	assign ocp_trip = !ocp_fault_q && ocp_cnt_q == 9'(OCP_DEB_CYC - 1);
	assign ocp_retry = ocp_fault_q && ocp_ms_q == 8'(OCP_RETRY_MS);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ocp_fault_q <= 1'b0;
			ocp_cnt_q <= 9'h000;
			ocp_ms_q <= 8'h00;
		end else begin
			if (ocp_trip) ocp_fault_q <= 1'b1;
			else if (ocp_retry) ocp_fault_q <= 1'b0;
			if (ocp_fault_q || !f.battery_node_oc) ocp_cnt_q <= 9'h000;
			else ocp_cnt_q <= ocp_cnt_q + 9'h001;
			// a rail that recovers restarts the low-time count
			if (!ocp_fault_q || !f.sys_low || ocp_retry) ocp_ms_q <= 8'h00;
			else if (ms_tick) ocp_ms_q <= ocp_ms_q + 8'h01;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			battery_node_dis_en <= 1'b1;
			buck_en <= 1'b0;
		end else begin
			battery_node_dis_en <= !ocp_fault_q && !ocp_trip;
			buck_en <= f.input_valid && !ocp_fault_q && !ocp_trip && !f.tj_shdn;
		end
	end
	// ==========================================================
	// apb slave, no wait states, error on unmapped address
	logic [31:0] rd_mux;
	assign rd_mux = hit_ctrl ? ctrl_q :
		hit_stat ? {21'h0, ocp_fault_q, boost_sw_on, boost_mode, suspend,
			f.thm_low, f.input_valid, f.tj_shdn, 1'b0, state_q} :
		hit_tgt ? {23'h0, vterm_drop, 1'b0, ichg_pct} : 32'h0000_0000;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= CTRL_RST;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= acc_setup;
			pslverr <= acc_setup && !(hit_ctrl || hit_stat || hit_tgt);
			if (acc_setup) prdata <= rd_mux;
			if (psel && penable && pready && pwrite && hit_ctrl) ctrl_q <= pwdata;
		end
	end
	// ==========================================================
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_done_zero_cur: assert property (state_q == ST_DONE |=> ichg_pct == 7'h00)
		else $error("charge current not zero in done");
	chk_shdn_entry: assert property (f.tj_shdn |=> state_q == ST_TSHDN ##1 !charger_en)
		else $error("thermal shutdown not entered");
	chk_fault_hold: assert property (state_q == ST_TFAULT && f.input_valid
		&& !f.tj_shdn |=> state_q == ST_TFAULT)
		else $error("timer fault left with input present");
	chk_fault_stat: assert property (state_q == ST_TFAULT |=> stat_oe_n && !charger_en)
		else $error("status pin driven in timer fault");
	chk_done_restart: assert property (state_q == ST_DONE && f.battery_node_restart
		&& f.input_valid && !f.thm_low && !f.tj_shdn |=> state_q == ST_FASTCC ##1 !softstart_en)
		else $error("done did not restart without soft start");
	chk_boost_gate: assert property (boost_sw_on |-> $past(f.boost_en) && $past(f.charger_input_low))
		else $error("boost switch on without enable");
	chk_boost_open: assert property ($fell(boost_sw_on) && boost_mode
		|=> !boost_sw_on [*8])
		else $error("boost switch reclosed too soon");
	chk_ocp_deb: assert property ($rose(ocp_fault_q) |-> $past(f.battery_node_oc, 2))
		else $error("overcurrent fault without overcurrent");
	chk_ocp_off: assert property (ocp_fault_q |=> !battery_node_dis_en && !buck_en)
		else $error("discharge path on during overcurrent");
	chk_cc_single: assert property (cc1_src_en |-> !cc2_src_en && !cc_low_power)
		else $error("both source pins active");
	chk_thm_buck: assert property (f.thm_low && f.input_valid && !f.tj_shdn
		&& state_q != ST_TFAULT |=> state_q == ST_BUCK ##1 !charger_en)
		else $error("thermistor pin did not stop charging");
	chk_suspend: assert property ((f.cold || f.hot) |=> !charger_en && ichg_pct == 7'h00)
		else $error("charging in cold or hot zone");
	chk_topoff_end: assert property (state_q == ST_TOPOFF && topoff_done
		&& !to_expired && !f.battery_node_restart && f.input_valid && !f.tj_shdn && !f.thm_low
		|=> state_q == ST_DONE)
		else $error("top-off did not end in done");
	chk_done_stay: assert property (state_q == ST_DONE && !f.battery_node_restart
		&& f.input_valid && !f.tj_shdn && !f.thm_low |=> state_q == ST_DONE)
		else $error("done left without restart");
	chk_idle_zero: assert property (state_q == ST_IDLE
		|=> ichg_pct == 7'h00 && !charger_en && st_ms_q == 24'h000000)
		else $error("idle with current or timer");
	chk_timer_fault: assert property (state_q inside {ST_FASTCC, ST_CV} && fc_expired
		&& f.input_valid && !f.tj_shdn && !f.thm_low |=> state_q == ST_TFAULT)
		else $error("safety timer expiry missed");
	chk_shdn_off: assert property (f.tj_shdn |=> !charger_en && !buck_en)
		else $error("charger on during thermal shutdown");
	chk_cool_half: assert property (jeita_full && f.cool && !f.cold && !f.hot
		&& charging && tj_excess == 5'h00 |=> ichg_pct == CUR_COOL_PCT)
		else $error("cool zone current not halved");
	chk_warm_drop: assert property (jeita_full && f.warm && !f.hot |=> vterm_drop)
		else $error("warm zone termination not lowered");
	chk_hc_plain: assert property (!jeita_full && charging && !suspend
		&& tj_excess == 5'h00 |=> ichg_pct == CUR_FULL_PCT && !vterm_drop)
		else $error("hot/cold variant adjusted targets");
	chk_boost_blank: assert property ($rose(boost_sw_on) && $past(boost_mode)
		|=> (boost_sw_on || !boost_mode) [*8])
		else $error("retried switch opened inside on window");
	chk_boost_mode: assert property (boost_sw_on |-> boost_mode)
		else $error("boost switch on outside boost mode");
	chk_ocp_retry: assert property ($fell(ocp_fault_q) |-> $past(f.sys_low, 2))
		else $error("overcurrent retry without low rail");
	chk_ocp_reon: assert property ($fell(ocp_fault_q) |=> battery_node_dis_en)
		else $error("discharge path not restored on retry");
	chk_fold_zero: assert property (tj_excess >= FOLD_ZERO_C |=> ichg_pct == 7'h00)
		else $error("current not zero at foldback limit");
	chk_fold_step: assert property (charging && !suspend && !cool_cut
		&& tj_excess == 5'h01 |=> ichg_pct == CUR_FULL_PCT - FOLD_STEP_PCT)
		else $error("foldback step not applied");
endmodule

// [test/cpc_far_side.sv]
// Purpose: far side of the block: battery, adapter, load and host thermistor driver
// Assumes: comparators follow the physical levels at once
// Notes: faults exist only while the path they load is closed
module cpc_far_side import cpc_pkg::*; (
	input wire cpc_flags_t env,
	input wire logic host_pull_n,
	input wire logic heavy_load,
	input wire logic battery_node_short,
	input wire logic boost_sw_on,
	input wire logic battery_node_dis_en,
	output cpc_flags_t flags
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// thermistor wire, pulled up to the bias supply
	wire logic thm_level;
	// host only sinks, so a released pin reads high
	assign thm_level = host_pull_n ? 1'b1 : 1'b0;
	always_comb begin
		flags = env;
		flags.thm_low = ~thm_level;
		// no overload current while the switch is open
		flags.boost_ovl = heavy_load & boost_sw_on;
		flags.battery_node_oc = battery_node_short & battery_node_dis_en;
		// rail sags once the discharge path is cut
		flags.sys_low = ~battery_node_dis_en;
	end
endmodule

// [test/test_charger_protection_control.sv]
// Purpose: self-checking bench for the charger protection control
// Assumes: ms tick shortened to 4 cycles, all ms figures scale with it
// Notes: safety timer limits are too long to reach here
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
	$display("[FAIL] t=%0t got %h exp %h", $time, (a), (b)); end end
`define WT(c, n) for (int k = 0; k < (n) && !(c); k++) @(posedge pclk);
module test_charger_protection_control import cpc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TK = 4;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
	logic pready, pslverr, rerr;
	cpc_flags_t env = '0, flags;
	logic [4:0] tj_excess = 5'h00;
	logic host_pull_n = 1'b1, heavy_load = 1'b0, battery_node_short = 1'b0;
	logic charger_en, vterm_drop, softstart_en, stat_o, stat_oe_n, boost_mode, boost_sw_on;
	logic cc_low_power, cc1_src_en, cc2_src_en, battery_node_dis_en, buck_en;
	logic [6:0] ichg_pct;
	int n_fail = 0, tests_run = 0;
	// ==========================================================
	// design and far side
	cpc_top #(.TICK_CYC(TK)) dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
		.prdata, .pready, .pslverr, .flags_pin(flags), .tj_excess, .charger_en, .ichg_pct,
		.vterm_drop, .softstart_en, .stat_o, .stat_oe_n, .boost_mode, .boost_sw_on,
		.cc_low_power, .cc1_src_en, .cc2_src_en, .battery_node_dis_en, .buck_en);
	cpc_far_side far (.env, .host_pull_n, .heavy_load, .battery_node_short, .boost_sw_on,
		.battery_node_dis_en, .flags);
	always #12.5 pclk = ~pclk;
	// ==========================================================
	// tasks
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// no wait-state count assumed, the watchdog ends a hang
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// pin to outputs takes four edges
	task settle;
		repeat (6) @(posedge pclk);
	endtask
	task wst(input cpc_state_t s);
		for (int i = 0; i < 60; i++) begin
			apb(1'b0, REG_STATUS, 32'h0000_0000);
			if (rdat[2:0] === s) break;
		end
		`CHK(rdat[2:0], s)
	endtask
	task tend(input string nm);
		$display("test %s ended, checks %0d", nm, tests_run);
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		repeat (30000) @(posedge pclk);
		n_fail++;
		finish_test;
	end
	// ==========================================================
	// tests
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		`CHK(charger_en, 1'b0)
		`CHK(battery_node_dis_en, 1'b1)
		apb(1'b0, REG_CTRL, 32'h0000_0000);
		`CHK(rdat, CTRL_RST)
		apb(1'b1, REG_STATUS, 32'hFFFF_FFFF);
		wst(ST_IDLE);
		apb(1'b0, 8'h0C, 32'h0000_0000);
		`CHK({rerr, rdat}, 33'h1_0000_0000)
		tend("reset");
		env.input_valid <= 1'b1;
		wst(ST_FASTCC);
		env.battery_node_at_reg <= 1'b1;
		wst(ST_CV);
		env.term_low <= 1'b1;
		wst(ST_TOPOFF);
		repeat (TOPOFF_MS * TK - 20) @(posedge pclk);
		apb(1'b0, REG_STATUS, 32'h0000_0000);
		`CHK(rdat[2:0], ST_TOPOFF)
		wst(ST_DONE);
		env.battery_node_at_reg <= 1'b0;
		env.term_low <= 1'b0;
		settle;
		`CHK(ichg_pct, 7'h00)
		`CHK({stat_o, stat_oe_n}, 2'b01)
		wst(ST_DONE);
		env.battery_node_restart <= 1'b1;
		wst(ST_FASTCC);
		env.battery_node_restart <= 1'b0;
		settle;
		`CHK(softstart_en, 1'b0)
		`CHK(ichg_pct, CUR_FULL_PCT)
		`CHK({stat_o, stat_oe_n}, 2'b00)
		tend("charge cycle");
		env.cool <= 1'b1;
		settle;
		apb(1'b0, REG_TARGET, 32'h0000_0000);
		`CHK(rdat[6:0], CUR_COOL_PCT)
		env.cool <= 1'b0;
		env.warm <= 1'b1;
		settle;
		`CHK({vterm_drop, ichg_pct}, {1'b1, CUR_FULL_PCT})
		env.warm <= 1'b0;
		env.cold <= 1'b1;
		settle;
		`CHK({charger_en, ichg_pct}, 8'h00)
		env.cold <= 1'b0;
		env.hot <= 1'b1;
		settle;
		`CHK(charger_en, 1'b0)
		env.hot <= 1'b0;
		apb(1'b1, REG_CTRL, 32'h0000_0000);
		env.cool <= 1'b1;
		settle;
		`CHK(ichg_pct, CUR_FULL_PCT)
		env.cool <= 1'b0;
		env.warm <= 1'b1;
		settle;
		`CHK(vterm_drop, 1'b0)
		env.warm <= 1'b0;
		env.hot <= 1'b1;
		settle;
		`CHK(charger_en, 1'b0)
		env.hot <= 1'b0;
		apb(1'b1, REG_CTRL, 32'h0000_0001);
		settle;
		`CHK(charger_en, 1'b1)
		tend("temperature zones");
		for (int e = 0; e <= 20; e++) begin
			tj_excess <= 5'(e);
			settle;
			`CHK(ichg_pct, 7'(int'(CUR_FULL_PCT) - int'(FOLD_STEP_PCT) * e))
		end
		tj_excess <= 5'h00;
		tend("foldback");
		host_pull_n <= 1'b0;
		wst(ST_BUCK);
		settle;
		`CHK(charger_en, 1'b0)
		host_pull_n <= 1'b1;
		wst(ST_FASTCC);
		env.tj_shdn <= 1'b1;
		wst(ST_TSHDN);
		host_pull_n <= 1'b0;
		settle;
		apb(1'b0, REG_STATUS, 32'h0000_0000);
		`CHK(rdat[4:0], 5'h14)
		`CHK(charger_en, 1'b0)
		env.tj_shdn <= 1'b0;
		host_pull_n <= 1'b1;
		wst(ST_FASTCC);
		tend("thermistor and shutdown");
		battery_node_short <= 1'b1;
		repeat (OCP_DEB_CYC - 50) @(posedge pclk);
		`CHK(battery_node_dis_en, 1'b1)
		`WT(!battery_node_dis_en, 100)
		`CHK({battery_node_dis_en, buck_en}, 2'b00)
		repeat (OCP_RETRY_MS * TK - 50) @(posedge pclk);
		`CHK(battery_node_dis_en, 1'b0)
		`WT(battery_node_dis_en, 100)
		`CHK(battery_node_dis_en, 1'b1)
		`WT(!battery_node_dis_en, 500)
		`CHK(battery_node_dis_en, 1'b0)
		battery_node_short <= 1'b0;
		`WT(battery_node_dis_en, 600)
		`CHK(battery_node_dis_en, 1'b1)
		tend("overcurrent");
		env.input_valid <= 1'b0;
		wst(ST_IDLE);
		settle;
		`CHK({charger_en, ichg_pct}, 8'h00)
		env.boost_en <= 1'b1;
		settle;
		`CHK(boost_mode, 1'b0)
		env.charger_input_low <= 1'b1;
		settle;
		`CHK({boost_mode, boost_sw_on, cc_low_power, cc1_src_en}, 4'hE)
		env.cc1_sink <= 1'b1;
		settle;
		`CHK({cc_low_power, cc1_src_en, cc2_src_en}, 3'h2)
		env.cc1_sink <= 1'b0;
		settle;
		`CHK({cc_low_power, cc1_src_en, cc2_src_en}, 3'h4)
		env.cc2_sink <= 1'b1;
		settle;
		`CHK({cc_low_power, cc1_src_en, cc2_src_en}, 3'h1)
		heavy_load <= 1'b1;
		`WT(!boost_sw_on, 20)
		`CHK(boost_sw_on, 1'b0)
		repeat (BOOST_OFF_MS * TK - 100) @(posedge pclk);
		`CHK(boost_sw_on, 1'b0)
		`WT(boost_sw_on, 200)
		`CHK(boost_sw_on, 1'b1)
		repeat (BOOST_ON_MS * TK - 40) @(posedge pclk);
		`CHK(boost_sw_on, 1'b1)
		`WT(!boost_sw_on, 100)
		`CHK(boost_sw_on, 1'b0)
		heavy_load <= 1'b0;
		env.boost_en <= 1'b0;
		settle;
		`CHK(boost_mode, 1'b0)
		tend("reverse boost");
		finish_test;
	end
endmodule
